// ==== design/obc_pkg.sv ====
/*
 * Package for the option byte configuration decoder: option byte field
 * positions, factory values, decoded codes, register map and check flags.
 * Assumes one 125 MHz clock domain and a classic Wishbone register port.
 */
package obc_pkg;

   // Clock
   localparam int          CLK_HZ         = 125000000;

   // Option byte 0 layout
   localparam int          B0_AWU_CLK     = 7;
   localparam int          B0_RANGE_HI    = 6;
   localparam int          B0_RANGE_LO    = 4;
   localparam int          B0_RSV_HI      = 3;
   localparam int          B0_RSV_LO      = 2;
   localparam int          B0_ROM_PROT    = 1;
   localparam int          B0_EE_PROT     = 0;

   // Option byte 1 layout
   localparam int          B1_FACTOR      = 7;
   localparam int          B1_PLL_BYPASS  = 6;
   localparam int          B1_RSV         = 5;
   localparam int          B1_OSC         = 4;
   localparam int          B1_LVD_HI      = 3;
   localparam int          B1_LVD_LO      = 2;
   localparam int          B1_WDG_SW      = 1;
   localparam int          B1_WATCHDOG_RESET_ON_HALT    = 0;

   // Factory values of the option bytes
   localparam logic [7:0]  OPT0_DEFAULT   = 8'hfc;
   localparam logic [7:0]  OPT1_DEFAULT   = 8'hcf;

   // Values the reserved bits must hold
   localparam logic [1:0]  B0_RSV_VALUE   = 2'h3;
   localparam logic        B1_FACTOR_X8   = 1'h1;
   localparam logic        B1_RSV_VALUE   = 1'h0;

   // Source range codes
   localparam logic [2:0]  RANGE_LOW_POWER   = 3'h0;
   localparam logic [2:0]  RANGE_MED_POWER   = 3'h1;
   localparam logic [2:0]  RANGE_MED_SPEED   = 3'h2;
   localparam logic [2:0]  RANGE_HIGH_SPEED  = 3'h3;
   localparam logic [2:0]  RANGE_SLOW_XTAL   = 3'h4;
   localparam logic [2:0]  RANGE_EXT_CLOCK   = 3'h5;

   // Low voltage detector codes
   localparam logic [1:0]  LVD_OFF        = 2'h3;
   localparam logic [1:0]  LVD_HIGH       = 2'h2;

   // Register map (byte addresses)
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  REG_OPT0       = 8'h00;
   localparam logic [7:0]  REG_OPT1       = 8'h04;
   localparam logic [7:0]  REG_DECODED    = 8'h08;
   localparam logic [7:0]  REG_CTRL       = 8'h0c;
   localparam logic [7:0]  REG_CHECK      = 8'h10;

   // Control register
   localparam int          CTRL_SUPPLY_HIGH = 0;
   localparam logic        CTRL_RESET       = 1'h0;

   // Check flags
   localparam int          CHK_W          = 5;
   localparam int          CHK_AWU_OSC    = 0;
   localparam int          CHK_RSV0       = 1;
   localparam int          CHK_RSV1       = 2;
   localparam int          CHK_RANGE      = 3;
   localparam int          CHK_PLL        = 4;

   // Decoded register layout
   localparam int          DEC_RANGE_LO   = 0;
   localparam int          DEC_WAKE_CLK   = 3;
   localparam int          DEC_EXT_PIN    = 4;
   localparam int          DEC_RC_ON      = 5;
   localparam int          DEC_PLL_BYP    = 6;
   localparam int          DEC_LVD_EN     = 7;
   localparam int          DEC_LVD_LO     = 8;
   localparam int          DEC_WDG_HW     = 10;
   localparam int          DEC_WATCHDOG_RESET_ON_HALT   = 11;
   localparam int          DEC_ROM_PROT   = 12;
   localparam int          DEC_EE_PROT    = 13;
   localparam int          DEC_VALID      = 14;

   // Effective range: the slow crystal whenever the wakeup clock uses it
   function automatic logic [2:0] obc_eff_range(input logic [7:0] b0);
      if (!b0[B0_AWU_CLK]) begin
         return RANGE_SLOW_XTAL;
      end
      return b0[B0_RANGE_HI:B0_RANGE_LO];
   endfunction : obc_eff_range

endpackage : obc_pkg

// ==== design/obc_opt_store.sv ====
/*
 * Non-volatile option byte store, written only by the programming tool.
 * Assumes por_i pulses once at power-up to load the factory values; the
 * system reset leaves the store alone, as a real non-volatile cell would.
 */
`timescale 1ns/1ps
module obc_opt_store
   import obc_pkg::*;
(
   // Clock and power-on
   input  wire logic       clk_i,
   input  wire logic       por_i,
   // Programming port
   input  wire logic       prog_mode_i,
   input  wire logic       prog_we_i,
   input  wire logic       prog_sel_i,
   input  wire logic [7:0] prog_wdata_i,
   // Stored bytes
   output logic      [7:0] opt0_o,
   output logic      [7:0] opt1_o
);
   import obc_pkg::*;

   typedef struct packed {
      logic [7:0] byte0;
      logic [7:0] byte1;
   } obc_store_t;

   obc_store_t st;
   obc_store_t next_st;

   always_comb begin
      next_st = st;
      if (por_i) begin
         next_st.byte0 = OPT0_DEFAULT;
         next_st.byte1 = OPT1_DEFAULT;
      end else if (prog_mode_i && prog_we_i) begin
         if (prog_sel_i) begin
            next_st.byte1 = prog_wdata_i;
         end else begin
            next_st.byte0 = prog_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign opt0_o = st.byte0;
   assign opt1_o = st.byte1;

endmodule : obc_opt_store

// ==== design/obc_combo_check.sv ====
/*
 * Combinational check of option byte values against the valid list.
 * Assumes the caller registers the result; the supply range comes from
 * software, since the decoder cannot measure the supply itself.
 */
`timescale 1ns/1ps
module obc_combo_check
   import obc_pkg::*;
(
   // Option bytes
   input  wire logic [7:0]       opt0_i,
   input  wire logic [7:0]       opt1_i,
   input  wire logic             supply_high_i,
   // Flags, one per violation
   output logic      [CHK_W-1:0] check_o
);
   import obc_pkg::*;

   logic [2:0] raw_range;
   logic       pll_on;

   always_comb begin
      raw_range = opt0_i[B0_RANGE_HI:B0_RANGE_LO];
      pll_on    = !opt1_i[B1_PLL_BYPASS];
      check_o   = '0;
      // Slow crystal wakeup needs the RC oscillator on
      check_o[CHK_AWU_OSC] = !opt0_i[B0_AWU_CLK] && opt1_i[B1_OSC];
      check_o[CHK_RSV0]    = opt0_i[B0_RSV_HI:B0_RSV_LO] != B0_RSV_VALUE;
      check_o[CHK_RSV1]    = opt1_i[B1_FACTOR] != B1_FACTOR_X8
                             || opt1_i[B1_RSV] != B1_RSV_VALUE;
      // Codes above external clock are reserved, only looked at when used
      check_o[CHK_RANGE]   = opt0_i[B0_AWU_CLK] && opt1_i[B1_OSC]
                             && raw_range > RANGE_EXT_CLOCK;
      // High supply: x8 factor only, even when bypassed; low supply: no x8 multiplier unless bypassed
      if (supply_high_i) begin
         check_o[CHK_PLL] = opt1_i[B1_FACTOR] != B1_FACTOR_X8;
      end else begin
         check_o[CHK_PLL] = pll_on && opt1_i[B1_FACTOR] == B1_FACTOR_X8;
      end
   end

endmodule : obc_combo_check

// ==== design/obc_decoder.sv ====
/*
 * Option byte configuration decoder: samples the two option bytes while
 * reset is held, decodes them into clock, supervisor, watchdog and
 * protection settings, checks the combination and shows it on Wishbone.
 * Assumes a synchronous active-high reset held at least one clock edge
 * and a classic Wishbone master; the programming tool drives prog_*.
 */
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module obc_decoder
   import obc_pkg::*;
(
   // Clock and resets
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              por_i,
   // Programming tool port
   input  wire logic              prog_mode_i,
   input  wire logic              prog_we_i,
   input  wire logic              prog_sel_i,
   input  wire logic [7:0]        prog_wdata_i,
   output logic      [7:0]        prog_rdata_o,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Decoded configuration
   output logic                   wakeup_clock_select_o,
   output logic                   slow_crystal_source_o,
   output logic      [2:0]        clock_source_range_o,
   output logic                   ext_clock_pin_o,
   output logic                   rc_osc_on_o,
   output logic                   pll_bypass_o,
   output logic                   lvd_enable_o,
   output logic      [1:0]        low_voltage_detect_level_o,
   output logic                   watchdog_hw_o,
   output logic                   watchdog_reset_on_halt_o,
   output logic                   rom_read_protect_o,
   output logic                   eeprom_read_protect_o,
   output logic                   config_valid_o,
   output logic      [CHK_W-1:0]  config_check_o
);
   import obc_pkg::*;

   typedef struct packed {
      logic [7:0]       opt0;
      logic [7:0]       opt1;
      logic             wake_clk;
      logic             slow_xtal;
      logic [2:0]       range;
      logic             ext_pin;
      logic             rc_on;
      logic             pll_byp;
      logic             lvd_en;
      logic [1:0]       lvd_lvl;
      logic             wdg_hw;
      logic             watchdog_reset_on_halt;
      logic             rom_prot;
      logic             ee_prot;
      logic             supply_high;
      logic [CHK_W-1:0] check;
      logic             valid;
      logic [7:0]       prog_rdata;
      logic             ack;
      logic [31:0]      rdata;
   } obc_state_t;

   obc_state_t       st;
   obc_state_t       next_st;
   logic [7:0]       nv_opt0;
   logic [7:0]       nv_opt1;
   logic [CHK_W-1:0] check_now;
   logic [31:0]      decoded_word;
   logic [2:0]       eff_range;

   obc_opt_store u_store (
      .clk_i        (clk_i),
      .por_i        (por_i),
      .prog_mode_i  (prog_mode_i),
      .prog_we_i    (prog_we_i),
      .prog_sel_i   (prog_sel_i),
      .prog_wdata_i (prog_wdata_i),
      .opt0_o       (nv_opt0),
      .opt1_o       (nv_opt1)
   );

   // Checks the held bytes, so it follows the supply setting live
   obc_combo_check u_check (
      .opt0_i        (st.opt0),
      .opt1_i        (st.opt1),
      .supply_high_i (st.supply_high),
      .check_o       (check_now)
   );

   always_comb begin
      decoded_word = '0;
      decoded_word[DEC_RANGE_LO +: 3]  = st.range;
      decoded_word[DEC_WAKE_CLK]       = st.wake_clk;
      decoded_word[DEC_EXT_PIN]        = st.ext_pin;
      decoded_word[DEC_RC_ON]          = st.rc_on;
      decoded_word[DEC_PLL_BYP]        = st.pll_byp;
      decoded_word[DEC_LVD_EN]         = st.lvd_en;
      decoded_word[DEC_LVD_LO +: 2]    = st.lvd_lvl;
      decoded_word[DEC_WDG_HW]         = st.wdg_hw;
      decoded_word[DEC_WATCHDOG_RESET_ON_HALT]       = st.watchdog_reset_on_halt;
      decoded_word[DEC_ROM_PROT]       = st.rom_prot;
      decoded_word[DEC_EE_PROT]        = st.ee_prot;
      decoded_word[DEC_VALID]          = st.valid;
   end

   always_comb begin
      next_st   = st;
      eff_range = obc_eff_range(nv_opt0);

      // Sampling: follows the store while reset is held, frozen after
      if (rst_i) begin
         next_st.opt0      = nv_opt0;
         next_st.opt1      = nv_opt1;
         next_st.wake_clk  = nv_opt0[B0_AWU_CLK];
         next_st.slow_xtal = !nv_opt0[B0_AWU_CLK];
         next_st.range     = eff_range;
         next_st.ext_pin   = nv_opt1[B1_OSC] && eff_range == RANGE_EXT_CLOCK;
         next_st.rc_on     = !nv_opt1[B1_OSC];
         next_st.pll_byp   = nv_opt1[B1_PLL_BYPASS];
         next_st.lvd_lvl   = nv_opt1[B1_LVD_HI:B1_LVD_LO];
         next_st.lvd_en    = nv_opt1[B1_LVD_HI:B1_LVD_LO] != LVD_OFF;
         next_st.wdg_hw    = !nv_opt1[B1_WDG_SW];
         next_st.watchdog_reset_on_halt  = nv_opt1[B1_WATCHDOG_RESET_ON_HALT];
         next_st.rom_prot  = nv_opt0[B0_ROM_PROT];
         next_st.ee_prot   = nv_opt0[B0_EE_PROT];
      end

      // Reported after one clock so that it is a plain register
      next_st.check = check_now;
      next_st.valid = check_now == '0;

      // Readback to the tool only in programming mode, else zero
      if (prog_mode_i) begin
         next_st.prog_rdata = prog_sel_i ? nv_opt1 : nv_opt0;
      end else begin
         next_st.prog_rdata = '0;
      end

      // Wishbone: answer one cycle after the strobe, drop the next cycle
      next_st.ack   = cyc_i && stb_i && !st.ack;
      next_st.rdata = '0;
      if (cyc_i && stb_i && !st.ack) begin
         // The raw bytes are the sampled copy; the store itself is unmapped
         case (adr_i)
            REG_OPT0: begin
               next_st.rdata = {24'h000000, st.opt0};
            end
            REG_OPT1: begin
               next_st.rdata = {24'h000000, st.opt1};
            end
            REG_DECODED: begin
               next_st.rdata = decoded_word;
            end
            REG_CTRL: begin
               next_st.rdata = {31'h00000000, st.supply_high};
            end
            REG_CHECK: begin
               next_st.rdata = {{(32 - CHK_W){1'b0}}, st.check};
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end

      // Write lands on the acknowledge edge, where the master takes the answer
      if (cyc_i && stb_i && we_i && st.ack && adr_i == REG_CTRL && sel_i[0]) begin
         next_st.supply_high = dat_i[CTRL_SUPPLY_HIGH];
      end

      // Control state that is not a sampled option
      if (rst_i) begin
         next_st.supply_high = CTRL_RESET;
         next_st.ack         = 1'b0;
         next_st.rdata       = '0;
         next_st.prog_rdata  = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign prog_rdata_o               = st.prog_rdata;
   assign dat_o                      = st.rdata;
   assign ack_o                      = st.ack;
   assign wakeup_clock_select_o      = st.wake_clk;
   assign slow_crystal_source_o      = st.slow_xtal;
   assign clock_source_range_o       = st.range;
   assign ext_clock_pin_o            = st.ext_pin;
   assign rc_osc_on_o                = st.rc_on;
   assign pll_bypass_o               = st.pll_byp;
   assign lvd_enable_o               = st.lvd_en;
   assign low_voltage_detect_level_o = st.lvd_lvl;
   assign watchdog_hw_o              = st.wdg_hw;
   assign watchdog_reset_on_halt_o   = st.watchdog_reset_on_halt;
   assign rom_read_protect_o         = st.rom_prot;
   assign eeprom_read_protect_o      = st.ee_prot;
   assign config_valid_o             = st.valid;
   assign config_check_o             = st.check;

endmodule : obc_decoder

// ==== testbench/obc_decoder_sva.sv ====
/* Assertions on the decoded option byte outputs and the tool readback of obc_decoder.
   Assumes por_i loads the store once and reset samples it. */
`timescale 1ns/1ps
module obc_decoder_sva
   import obc_pkg::*;
(
   // Clock and resets
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       por_i,
   // Programming port
   input  wire logic       prog_mode_i,
   input  wire logic       prog_we_i,
   input  wire logic       prog_sel_i,
   input  wire logic [7:0] prog_wdata_i,
   input  wire logic [7:0] prog_rdata_o,
   // Decoded configuration
   input  wire logic       wakeup_clock_select_o,
   input  wire logic       slow_crystal_source_o,
   input  wire logic [2:0] clock_source_range_o,
   input  wire logic       ext_clock_pin_o,
   input  wire logic       rc_osc_on_o,
   input  wire logic       pll_bypass_o,
   input  wire logic       lvd_enable_o,
   input  wire logic [1:0] low_voltage_detect_level_o,
   input  wire logic       watchdog_hw_o,
   input  wire logic       watchdog_reset_on_halt_o,
   input  wire logic       rom_read_protect_o,
   input  wire logic       eeprom_read_protect_o
);
   logic [7:0] m0, m1, q0, q1;
   wire logic wr = prog_mode_i && prog_we_i;
   wire logic [14:0] dec_vec = {wakeup_clock_select_o, slow_crystal_source_o, clock_source_range_o,
      ext_clock_pin_o, rc_osc_on_o, pll_bypass_o, lvd_enable_o, low_voltage_detect_level_o,
      watchdog_hw_o, watchdog_reset_on_halt_o, rom_read_protect_o, eeprom_read_protect_o};
   // Mirror of the store, which is not a port; q is its value one edge back
   always_ff @(posedge clk_i) begin
      m0 <= por_i ? OPT0_DEFAULT : (wr && !prog_sel_i) ? prog_wdata_i : m0;
      m1 <= por_i ? OPT1_DEFAULT : (wr && prog_sel_i) ? prog_wdata_i : m1;
      q0 <= m0;
      q1 <= m1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (por_i);
   sequence s_sampled; $past(rst_i) && !$past(por_i); endsequence
   property p_wake; s_sampled |-> wakeup_clock_select_o == q0[7] && slow_crystal_source_o != q0[7]; endproperty
   a_wake: assert property (p_wake) else $error("wakeup clock select wrong");
   property p_range; s_sampled |-> clock_source_range_o == (q0[7] ? q0[6:4] : 3'h4); endproperty
   a_range: assert property (p_range) else $error("source range wrong");
   property p_prot; s_sampled |-> rom_read_protect_o == q0[1] && eeprom_read_protect_o == q0[0]; endproperty
   a_prot: assert property (p_prot) else $error("readout protection wrong");
   property p_pll; s_sampled |-> pll_bypass_o == q1[6]; endproperty
   a_pll: assert property (p_pll) else $error("pll bypass wrong");
   property p_osc; s_sampled |-> rc_osc_on_o != q1[4] && ext_clock_pin_o == (q1[4] && q0[7:4] == 4'hd); endproperty
   a_osc: assert property (p_osc) else $error("oscillator select wrong");
   property p_lvd; s_sampled |-> lvd_enable_o == (q1[3:2] != LVD_OFF) && low_voltage_detect_level_o == q1[3:2];
   endproperty
   a_lvd: assert property (p_lvd) else $error("detector setting wrong");
   property p_wdg; s_sampled |-> watchdog_hw_o != q1[1] && watchdog_reset_on_halt_o == q1[0]; endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog setting wrong");
   property p_hold; !rst_i && !$past(rst_i) |-> $stable(dec_vec); endproperty
   a_hold: assert property (p_hold) else $error("decoded output moved outside reset");
   property p_prog; !prog_mode_i |=> prog_rdata_o == 8'h00; endproperty
   a_prog: assert property (p_prog) else $error("option byte visible outside programming mode");
endmodule : obc_decoder_sva

bind obc_decoder obc_decoder_sva obc_decoder_sva_inst (.clk_i, .rst_i, .por_i, .prog_mode_i, .prog_we_i,
   .prog_sel_i, .prog_wdata_i, .prog_rdata_o, .wakeup_clock_select_o, .slow_crystal_source_o,
   .clock_source_range_o, .ext_clock_pin_o, .rc_osc_on_o, .pll_bypass_o, .lvd_enable_o,
   .low_voltage_detect_level_o, .watchdog_hw_o, .watchdog_reset_on_halt_o, .rom_read_protect_o,
   .eeprom_read_protect_o);

// ==== testbench/obc_prog_tool.sv ====
/* Programming tool model: writes option bytes and reads them back.
   Assumes the decoder's programming port on the far side. */
`timescale 1ns/1ps
module obc_prog_tool (
   // Clock and readback
   input  wire logic       clk_i,
   input  wire logic [7:0] prog_rdata_i,
   // Programming port
   output logic            prog_mode_o,
   output logic            prog_we_o,
   output logic            prog_sel_o,
   output logic      [7:0] prog_wdata_o
);
   initial {prog_mode_o, prog_we_o, prog_sel_o, prog_wdata_o} = 11'h000;
   // Bytes go out as given, so a caller can break the reserved values on purpose
   task automatic put_byte(input logic sel, input logic [7:0] val, input logic mode, output logic [7:0] back);
      @(posedge clk_i);
      prog_mode_o  <= mode;
      prog_we_o    <= 1'b1;
      prog_sel_o   <= sel;
      prog_wdata_o <= val;
      @(posedge clk_i);
      prog_we_o    <= 1'b0;
      prog_wdata_o <= ~val;
      // Readback lands one edge after the write edge and is taken on the edge after that
      repeat (2) @(posedge clk_i);
      back = prog_rdata_i;
      prog_mode_o  <= 1'b0;
   endtask : put_byte
endmodule : obc_prog_tool

// ==== testbench/obc_decoder_test.sv ====
/* Bench for obc_decoder: programs option bytes, resets, checks pins and registers.
   Assumes the tool model and a 125 MHz clock. */
`timescale 1ns/1ps
module obc_decoder_test;
   import obc_pkg::*;
   logic              clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, prog_mode_i, prog_we_i, prog_sel_i;
   logic        [7:0] prog_wdata_i, prog_rdata_o, adr_i = 8'h00, bk;
   logic              cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, config_valid_o;
   logic        [3:0] sel_i = 4'h0;
   logic       [31:0] dat_i = 32'h0, dat_o, rd;
   logic              wakeup_clock_select_o, slow_crystal_source_o, ext_clock_pin_o, rc_osc_on_o;
   logic              pll_bypass_o, lvd_enable_o, watchdog_hw_o, watchdog_reset_on_halt_o;
   logic              rom_read_protect_o, eeprom_read_protect_o;
   logic        [2:0] clock_source_range_o;
   logic        [1:0] low_voltage_detect_level_o;
   logic  [CHK_W-1:0] config_check_o;
   int                err_count = 0, comparisons = 0;
   logic       [15:0] cfg [10] = '{16'hfccf, 16'h8ed8, 16'h9ddd, 16'had9a, 16'hbf9a,
                                   16'hcc1b, 16'hdcd4, 16'hecd3, 16'h7cd3, 16'h70e3};
   logic        [9:0] hi = 10'h030;

   always #4 clk_i = ~clk_i;

   obc_decoder obc_decoder_inst (.clk_i, .rst_i, .por_i, .prog_mode_i, .prog_we_i, .prog_sel_i, .prog_wdata_i,
      .prog_rdata_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .wakeup_clock_select_o,
      .slow_crystal_source_o, .clock_source_range_o, .ext_clock_pin_o, .rc_osc_on_o, .pll_bypass_o,
      .lvd_enable_o, .low_voltage_detect_level_o, .watchdog_hw_o, .watchdog_reset_on_halt_o,
      .rom_read_protect_o, .eeprom_read_protect_o, .config_valid_o, .config_check_o);
   obc_prog_tool obc_prog_tool_inst (.clk_i, .prog_rdata_i(prog_rdata_o), .prog_mode_o(prog_mode_i),
      .prog_we_o(prog_we_i), .prog_sel_o(prog_sel_i), .prog_wdata_o(prog_wdata_i));

   task automatic give_verdict;
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      chk({31'h0, ack_o}, 32'h1, "bus ack");
   endtask : wb

   function automatic logic [4:0] flags(input logic [7:0] b0, input logic [7:0] b1, input logic sh);
      return {sh ? !b1[7] : (!b1[6] && b1[7]), b0[7] && b1[4] && b0[6:4] > 3'h5,
              !b1[7] || b1[5], b0[3:2] != 2'h3, !b0[7] && b1[4]};
   endfunction : flags

   function automatic logic [31:0] exp_dec(input logic [7:0] b0, input logic [7:0] b1, input logic sh);
      logic [2:0] r;
      r = b0[7] ? b0[6:4] : 3'h4;
      return {17'h0, flags(b0, b1, sh) == 5'h0, b0[0], b0[1], b1[0], !b1[1], b1[3:2], b1[3:2] != 2'h3,
              b1[6], !b1[4], b1[4] && r == 3'h5, b0[7], r};
   endfunction : exp_dec

   task automatic chk_pins(input logic [31:0] e);
      chk({16'h0, slow_crystal_source_o, config_valid_o, eeprom_read_protect_o, rom_read_protect_o,
           watchdog_reset_on_halt_o, watchdog_hw_o, low_voltage_detect_level_o, lvd_enable_o, pll_bypass_o,
           rc_osc_on_o, ext_clock_pin_o, wakeup_clock_select_o, clock_source_range_o},
          {16'h0, !e[3], e[14:0]}, "decoded pins");
   endtask : chk_pins

   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   task automatic run_cfg(input logic [7:0] b0, input logic [7:0] b1, input logic sh);
      obc_prog_tool_inst.put_byte(1'b0, b0, 1'b1, bk);
      chk({24'h0, bk}, {24'h0, b0}, "readback byte 0");
      obc_prog_tool_inst.put_byte(1'b1, b1, 1'b1, bk);
      do_reset();
      wb(1'b1, REG_CTRL, {31'h0, sh}, rd);
      repeat (2) @(posedge clk_i);
      chk_pins(exp_dec(b0, b1, sh));
      chk({27'h0, config_check_o}, {27'h0, flags(b0, b1, sh)}, "check pins");
      wb(1'b0, REG_DECODED, 32'h0, rd);
      chk(rd, exp_dec(b0, b1, sh), "decoded register");
      wb(1'b0, REG_CHECK, 32'h0, rd);
      chk(rd, {27'h0, flags(b0, b1, sh)}, "check flags");
      wb(1'b0, REG_CTRL, 32'h0, rd);
      chk(rd, {31'h0, sh}, "supply control readback");
   endtask : run_cfg

   initial begin
      @(posedge clk_i);
      por_i <= 1'b0;
      repeat (9) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         run_cfg(cfg[i][15:8], cfg[i][7:0], hi[i]);
      end
      // Refused outside programming mode, then a real write held off until reset
      obc_prog_tool_inst.put_byte(1'b0, 8'h8e, 1'b0, bk);
      chk({24'h0, bk}, 32'h0, "readback outside mode");
      obc_prog_tool_inst.put_byte(1'b1, 8'hd8, 1'b1, bk);
      chk_pins(exp_dec(8'h70, 8'he3, 1'b0));
      do_reset();
      repeat (3) @(posedge clk_i);
      chk_pins(exp_dec(8'h70, 8'hd8, 1'b0));
      wb(1'b0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      wb(1'b1, REG_OPT0, 32'hff, rd);
      wb(1'b0, REG_OPT0, 32'h0, rd);
      chk(rd, 32'h70, "option byte not writable from bus");
      wb(1'b0, REG_OPT1, 32'h0, rd);
      chk(rd, 32'hd8, "sampled byte 1 after reset");
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end
endmodule : obc_decoder_test
